/* rtl/bld_pkg.sv */
package bld_pkg;
  localparam logic [7:0] OPC_ESC = 8'h0F;
  localparam logic [7:0] OPC_ARPL = 8'h63;
  localparam logic [7:0] OPC_BOUND = 8'h62;
  localparam logic [7:0] OPC_GRP1 = 8'h80;
  localparam logic [7:0] OPC_BB0 = 8'h3A;
  localparam logic [7:0] OPC_BB1 = 8'h3B;
  localparam logic [7:0] OPC_BSF = 8'hBC;
  localparam logic [7:0] OPC_BSR = 8'hBD;
  localparam logic [7:0] OPC_BTI = 8'hBA;
  localparam logic [7:0] OPC_BT = 8'hA3;
  localparam logic [7:0] OPC_BTC = 8'hBB;
  localparam logic [7:0] OPC_BTR = 8'hB3;
  localparam logic [7:0] OPC_BTS = 8'hAB;
  localparam logic [4:0] OPC_BSWAP_HI = 5'h19;
  localparam logic [2:0] GRP_ADD = 3'h0;
  localparam logic [2:0] GRP_AND = 3'h4;
  localparam logic [2:0] GRP_BT = 3'h4;
  localparam logic [2:0] GRP_BTS = 3'h5;
  localparam logic [2:0] GRP_BTR = 3'h6;
  localparam logic [2:0] GRP_BTC = 3'h7;
  localparam logic [7:0] CYC_ONE = 8'h01;
  localparam logic [7:0] CYC_BLIT = 8'h02;
  localparam logic [7:0] CYC_BOUND_IN = 8'h07;
  localparam logic [7:0] CYC_BOUND_OUT = 8'h08;
  localparam logic [7:0] CYC_SCAN_REG = 8'h04;
  localparam logic [7:0] CYC_BSF_MEM = 8'h09;
  localparam logic [7:0] CYC_BSR_MEM = 8'h0B;
  localparam logic [7:0] CYC_BSWAP = 8'h06;
  localparam logic [7:0] CYC_ARPL = 8'h09;
  localparam logic [7:0] CYC_BT_MEM = 8'h07;
  localparam logic [7:0] CYC_BTM_REG = 8'h02;
  localparam logic [7:0] CYC_BTM_MEM = 8'h08;
  localparam logic [3:0] BOUND_VEC = 4'h5;
  typedef enum logic [3:0] {
    BLD_OP_NONE = 4'h0, BLD_OP_ADD = 4'h1, BLD_OP_AND = 4'h2,
    BLD_OP_ARPL = 4'h3, BLD_OP_BB0 = 4'h4, BLD_OP_BB1 = 4'h5,
    BLD_OP_BOUND = 4'h6, BLD_OP_BSF = 4'h7, BLD_OP_BSR = 4'h8,
    BLD_OP_BSWAP = 4'h9, BLD_OP_BT = 4'hA, BLD_OP_BTC = 4'hB,
    BLD_OP_BTR = 4'hC, BLD_OP_BTS = 4'hD, BLD_OP_BAD = 4'hE
  } bld_op_type;
  // flag write mask, one bit each: of sf zf af pf cf
  typedef struct packed {
    logic of_w, sf_w, zf_w, af_w, pf_w, cf_w;
    logic of_clr, cf_clr, cf_from_bit;
  } bld_flag_type;
endpackage

/* rtl/bld_dec_if.sv */
`timescale 1ns/100ps
interface bld_dec_if;
  import bld_pkg::*;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [7:0] modrm;
  logic prot_mode;
  bld_op_type op;
  bld_flag_type flags;
  logic [7:0] base_cyc;
  logic mem_opnd;
  logic has_imm;
  logic two_byte;
  logic [2:0] reg_sel;
  modport dec (input byte0, byte1, modrm, prot_mode,
    output op, flags, base_cyc, mem_opnd, has_imm, two_byte, reg_sel);
  modport ctl (output byte0, byte1, modrm, prot_mode,
    input op, flags, base_cyc, mem_opnd, has_imm, two_byte, reg_sel);
endinterface

/* rtl/bld_opdec.sv */
`timescale 1ns/100ps
module bld_opdec
  import bld_pkg::*;
(
  bld_dec_if.dec d
);
  wire esc = (d.byte0 == OPC_ESC);
  wire is_mem = (d.modrm[7:6] != 2'h3);
  wire [2:0] grp = d.modrm[5:3];
  wire is_grp1 = (d.byte0[7:2] == OPC_GRP1[7:2]);
  wire is_add_rm = (d.byte0[7:1] == 7'h01);
  wire is_and_rr = (d.byte0[7:2] == 6'h08) && !is_mem;
  wire is_bswap = esc && (d.byte1[7:3] == OPC_BSWAP_HI);
  wire is_bti = esc && (d.byte1 == OPC_BTI);

  function automatic logic [7:0] pick(input logic mem,
                                      input logic [7:0] r,
                                      input logic [7:0] m);
    pick = mem ? m : r;
  endfunction

  bld_op_type op_w;
  always_comb begin
    op_w = BLD_OP_NONE;
    if (is_add_rm)
      op_w = BLD_OP_ADD;
    else if (is_grp1 && grp == GRP_ADD)
      op_w = BLD_OP_ADD;
    else if (is_and_rr)
      op_w = BLD_OP_AND;
    else if (is_grp1 && grp == GRP_AND)
      op_w = BLD_OP_AND;
    else if (d.byte0 == OPC_ARPL)
      op_w = d.prot_mode ? BLD_OP_ARPL : BLD_OP_BAD;
    else if (d.byte0 == OPC_BOUND)
      op_w = BLD_OP_BOUND;
    else if (esc && d.byte1 == OPC_BB0)
      op_w = BLD_OP_BB0;
    else if (esc && d.byte1 == OPC_BB1)
      op_w = BLD_OP_BB1;
    else if (esc && d.byte1 == OPC_BSF)
      op_w = BLD_OP_BSF;
    else if (esc && d.byte1 == OPC_BSR)
      op_w = BLD_OP_BSR;
    else if (is_bswap)
      op_w = BLD_OP_BSWAP;
    else if ((is_bti && grp == GRP_BT) || (esc && d.byte1 == OPC_BT))
      op_w = BLD_OP_BT;
    else if ((is_bti && grp == GRP_BTC) || (esc && d.byte1 == OPC_BTC))
      op_w = BLD_OP_BTC;
    else if ((is_bti && grp == GRP_BTR) || (esc && d.byte1 == OPC_BTR))
      op_w = BLD_OP_BTR;
    else if ((is_bti && grp == GRP_BTS) || (esc && d.byte1 == OPC_BTS))
      op_w = BLD_OP_BTS;
    else
      op_w = BLD_OP_BAD;
  end

  // immediate bit-index forms run the register latency even on memory
  wire bt_mem = is_mem && !is_bti;
  logic [7:0] cyc_w;
  always_comb begin
    unique case (op_w)
      BLD_OP_ARPL: cyc_w = CYC_ARPL;
      BLD_OP_BB0, BLD_OP_BB1: cyc_w = CYC_BLIT;
      BLD_OP_BOUND: cyc_w = CYC_BOUND_IN;
      BLD_OP_BSF: cyc_w = pick(is_mem, CYC_SCAN_REG, CYC_BSF_MEM);
      BLD_OP_BSR: cyc_w = pick(is_mem, CYC_SCAN_REG, CYC_BSR_MEM);
      BLD_OP_BSWAP: cyc_w = CYC_BSWAP;
      BLD_OP_BT: cyc_w = pick(bt_mem, CYC_ONE, CYC_BT_MEM);
      BLD_OP_BTC, BLD_OP_BTR, BLD_OP_BTS:
        cyc_w = pick(bt_mem, CYC_BTM_REG, CYC_BTM_MEM);
      default: cyc_w = CYC_ONE;
    endcase
  end

  bld_flag_type fl_w;
  always_comb begin
    fl_w = '0;
    unique case (op_w)
      BLD_OP_ADD: fl_w = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                           1'b0, 1'b0, 1'b0};
      BLD_OP_AND: fl_w = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                           1'b1, 1'b1, 1'b0};
      BLD_OP_ARPL, BLD_OP_BSF, BLD_OP_BSR:
        fl_w.zf_w = 1'b1;
      BLD_OP_BT, BLD_OP_BTC, BLD_OP_BTR, BLD_OP_BTS: begin
        fl_w.cf_w = 1'b1;
        fl_w.cf_from_bit = 1'b1;
      end
      default: fl_w = '0;
    endcase
  end

  assign d.op = op_w;
  assign d.base_cyc = cyc_w;
  assign d.flags = fl_w;
  assign d.mem_opnd = is_mem && !is_bswap && !esc ? is_mem :
                      (esc && !is_bswap && is_mem);
  assign d.has_imm = is_grp1 || is_bti;
  assign d.two_byte = esc;
  assign d.reg_sel = is_bswap ? d.byte1[2:0] : d.modrm[5:3];
endmodule

/* rtl/bld_core.sv */
`timescale 1ns/100ps
module bld_core
  import bld_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] modrm,
  input wire logic prot_mode,
  input wire logic [7:0] rep_count,
  input wire logic out_of_range,
  input wire logic mem_wait,
  output logic busy,
  output logic done,
  output bld_op_type op,
  output bld_flag_type flag_ctl,
  output logic has_imm,
  output logic [2:0] reg_sel,
  output logic mem_opnd,
  output logic bad_opcode,
  output logic blit_buf0_ptr_rewind,
  output logic blit_buf1_ptr_rewind,
  output logic int_req,
  output logic [3:0] int_vec
);
  typedef enum logic [1:0] {
    BLD_IDLE = 2'b00, BLD_RUN = 2'b01, BLD_FIN = 2'b11
  } bld_state_type;

  bld_dec_if dif();
  assign dif.byte0 = byte0;
  assign dif.byte1 = byte1;
  assign dif.modrm = modrm;
  assign dif.prot_mode = prot_mode;
  bld_opdec u_dec (.d(dif));

  bld_state_type state_r, state_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  bld_op_type op_r;
  logic fire_bound_r;

  // scans pay one clock per position only on the long path
  wire scan_op = (dif.op == BLD_OP_BSF) || (dif.op == BLD_OP_BSR);
  wire [8:0] extra = (scan_op && dif.mem_opnd) ? {1'b0, rep_count} :
                     9'h000;
  wire [8:0] bound_cyc = {1'b0, out_of_range ? CYC_BOUND_OUT :
                          CYC_BOUND_IN};
  wire [8:0] total = (dif.op == BLD_OP_BOUND) ? bound_cyc :
                     ({1'b0, dif.base_cyc} + extra);
  wire start = issue && (state_r == BLD_IDLE);
  // a stalled memory system freezes the countdown rather than dropping it
  wire tick = !mem_wait;
  // cnt_r keeps its last value once idle, so the state must gate the end
  wire last = (state_r == BLD_RUN) && (cnt_r == 9'h001) && tick;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      BLD_IDLE: if (start) begin
        state_nxt = BLD_RUN;
        cnt_nxt = total;
      end
      BLD_RUN: if (last) begin
        state_nxt = BLD_FIN;
      end else if (tick) begin
        cnt_nxt = cnt_r - 9'h001;
      end
      BLD_FIN: state_nxt = BLD_IDLE;
      default: state_nxt = BLD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= BLD_IDLE;
      cnt_r <= 9'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_r <= BLD_OP_NONE;
      flag_ctl <= '0;
      has_imm <= 1'b0;
      reg_sel <= 3'h0;
      mem_opnd <= 1'b0;
      bad_opcode <= 1'b0;
      fire_bound_r <= 1'b0;
    end else if (start) begin
      op_r <= dif.op;
      flag_ctl <= dif.flags;
      has_imm <= dif.has_imm;
      reg_sel <= dif.reg_sel;
      mem_opnd <= dif.mem_opnd;
      bad_opcode <= (dif.op == BLD_OP_BAD);
      fire_bound_r <= (dif.op == BLD_OP_BOUND) && out_of_range;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      blit_buf0_ptr_rewind <= 1'b0;
      blit_buf1_ptr_rewind <= 1'b0;
      int_req <= 1'b0;
      int_vec <= 4'h0;
    end else begin
      busy <= (state_nxt == BLD_RUN);
      done <= (state_r == BLD_RUN) && last;
      blit_buf0_ptr_rewind <= last && (op_r == BLD_OP_BB0);
      blit_buf1_ptr_rewind <= last && (op_r == BLD_OP_BB1);
      int_req <= last && fire_bound_r;
      int_vec <= (last && fire_bound_r) ? BOUND_VEC : 4'h0;
    end
  end
  assign op = op_r;

  // cycles spent in the run state without mem_wait for the current instruction
  logic [8:0] span_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      span_r <= 9'h000;
    else if (start)
      span_r <= 9'h000;
    else if (state_r == BLD_RUN && tick)
      span_r <= span_r + 9'h001;
  end

  sequence s_bb0_issue;
    start && dif.op == BLD_OP_BB0 && !mem_wait;
  endsequence
  sequence s_bb0_run;
    !mem_wait [*2];
  endsequence

  a_blit0_two_clk: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_bb0_issue ##1 s_bb0_run |=> blit_buf0_ptr_rewind && done)
    else $error("blit 0 rewind not at done");
  a_blit1_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    blit_buf1_ptr_rewind |-> done && op_r == BLD_OP_BB1)
    else $error("blit 1 rewind without op");
  a_bound_vec: assert property (@(posedge sys_clk) disable iff (!rst_n)
    int_req |-> int_vec == 4'h5 && op_r == BLD_OP_BOUND
      && span_r == 9'h008)
    else $error("bound interrupt wrong");
  a_bound_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done && op_r == BLD_OP_BOUND && !fire_bound_r |-> !int_req)
    else $error("bound interrupt in range");
  a_bswap_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done && op_r == BLD_OP_BSWAP |-> span_r == 9'h006)
    else $error("byte swap length wrong");
  a_and_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    op_r == BLD_OP_AND |-> flag_ctl.of_clr && flag_ctl.cf_clr)
    else $error("and flags not cleared");
  a_bt_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    op_r inside {BLD_OP_BT, BLD_OP_BTC, BLD_OP_BTR, BLD_OP_BTS}
      |-> flag_ctl.cf_from_bit && !flag_ctl.zf_w)
    else $error("bit test carry wrong");
  a_arpl_zf: assert property (@(posedge sys_clk) disable iff (!rst_n)
    done && op_r == BLD_OP_ARPL |-> span_r == 9'h009
      && flag_ctl.zf_w && !flag_ctl.cf_w)
    else $error("privilege adjust wrong");
  a_wait_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == BLD_RUN && mem_wait |=> $stable(span_r))
    else $error("wait did not hold count");
endmodule

/* dv/bld_core_tb.sv */
`timescale 1ns/100ps
module bld_core_tb;
  import bld_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  logic [7:0] byte0 = 8'h00;
  logic [7:0] byte1 = 8'h00;
  logic [7:0] modrm = 8'h00;
  logic prot_mode = 1'b0;
  logic [7:0] rep_count = 8'h00;
  logic out_of_range = 1'b0;
  logic mem_wait = 1'b0;
  logic busy, done, has_imm, mem_opnd, bad_opcode, rw0, rw1, int_req;
  logic [2:0] reg_sel;
  logic [3:0] int_vec;
  bld_op_type op;
  bld_flag_type fc;
  int mismatches = 0;
  int num_checks = 0;

  bld_core i_bld_core (.sys_clk(sys_clk), .rst_n(rst_n), .issue(issue),
    .byte0(byte0), .byte1(byte1), .modrm(modrm), .prot_mode(prot_mode),
    .rep_count(rep_count), .out_of_range(out_of_range),
    .mem_wait(mem_wait), .busy(busy), .done(done), .op(op),
    .flag_ctl(fc), .has_imm(has_imm), .reg_sel(reg_sel),
    .mem_opnd(mem_opnd), .bad_opcode(bad_opcode),
    .blit_buf0_ptr_rewind(rw0), .blit_buf1_ptr_rewind(rw1),
    .int_req(int_req), .int_vec(int_vec));

  always #12.5 sys_clk = ~sys_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what,
               seen, exp);
    end
  endtask

  // one instruction; poke tries a second issue while busy, wt stalls
  task automatic run(input logic [7:0] b0, input logic [7:0] b1,
    input logic [7:0] m, input logic pm, input logic [7:0] rc,
    input logic oor, input int wt, input logic poke,
    input bld_op_type eop, input int n);
    logic [31:0] cnt;
    cnt = 0;
    @(posedge sys_clk);
    issue <= 1'b1;
    byte0 <= b0;
    byte1 <= b1;
    modrm <= m;
    prot_mode <= pm;
    rep_count <= rc;
    out_of_range <= oor;
    @(posedge sys_clk);
    issue <= 1'b0;
    mem_wait <= wt > 0;
    while (cnt < 80 && done !== 1'b1) begin
      @(posedge sys_clk);
      cnt++;
      issue <= poke && cnt == 1;
      if (poke)
        byte1 <= OPC_BB0;
      mem_wait <= cnt < wt;
      #1;
      if (cnt == 1)
        chk(busy, n + wt > 1, "busy");
    end
    chk(cnt, n + wt, "latency");
    chk(busy, 1'b0, "busy at end");
    chk(op, eop, "op");
    chk(rw0, eop == BLD_OP_BB0, "rewind0");
    chk(rw1, eop == BLD_OP_BB1, "rewind1");
    chk(int_req, eop == BLD_OP_BOUND && oor, "int_req");
    if (oor)
      chk(int_vec, BOUND_VEC, "int_vec");
    chk(bad_opcode, eop == BLD_OP_BAD, "bad");
    @(posedge sys_clk);
    #1;
    chk({rw0, rw1, int_req, done}, 4'h0, "pulse width");
  endtask

  task automatic t_add;
    run(8'h03, 8'h00, 8'h06, 0, 0, 0, 0, 0, BLD_OP_ADD, 1);
    chk(mem_opnd, 1'b1, "add mem");
    for (int i = 0; i < 4; i++) begin
      run(8'(8'h80 + i), 8'h00, 8'hC3, 1, 0, 0, 0, 0, BLD_OP_ADD, 1);
      chk(has_imm, 1'b1, "add imm");
    end
    run(8'h80, 8'h00, 8'hC8, 0, 0, 0, 0, 0, BLD_OP_BAD, 1);
    // a miss stalls the countdown for exactly the wait cycles
    run(8'h62, 8'h00, 8'h06, 0, 0, 0, 3, 0, BLD_OP_BOUND, 7);
  endtask

  task automatic t_and;
    for (int i = 0; i < 4; i++) begin
      run(8'(8'h20 + i), 8'h00, 8'hC1, 0, 0, 0, 0, 0, BLD_OP_AND, 1);
      chk({fc.of_clr, fc.cf_clr, fc.sf_w, fc.zf_w, fc.pf_w, fc.cf_from_bit},
          6'h3E, "and flags");
    end
    run(8'h81, 8'h00, 8'hE0, 0, 0, 0, 0, 0, BLD_OP_AND, 1);
    chk(has_imm, 1'b1, "and imm");
  endtask

  task automatic t_arpl_blit_bound;
    run(8'h63, 8'h00, 8'hC0, 1, 0, 0, 0, 0, BLD_OP_ARPL, 9);
    chk({fc.of_w, fc.sf_w, fc.zf_w, fc.af_w, fc.pf_w, fc.cf_w}, 6'h08,
        "arpl flags");
    run(8'h63, 8'h00, 8'hC0, 0, 0, 0, 0, 0, BLD_OP_BAD, 1);
    run(OPC_ESC, 8'h3A, 8'h00, 0, 0, 0, 0, 0, BLD_OP_BB0, 2);
    chk(fc, 9'h000, "bb0 flags");
    run(OPC_ESC, 8'h3B, 8'h00, 1, 0, 0, 0, 0, BLD_OP_BB1, 2);
    chk(fc, 9'h000, "bb1 flags");
    run(8'h62, 8'h00, 8'h06, 1, 0, 1, 0, 0, BLD_OP_BOUND, 8);
    chk(fc, 9'h000, "bound flags");
  endtask

  task automatic t_scan_swap;
    run(OPC_ESC, 8'hBC, 8'hC0, 0, 9, 0, 0, 0, BLD_OP_BSF, 4);
    chk(fc, 9'h040, "bsf flags");
    run(OPC_ESC, 8'hBC, 8'h06, 0, 3, 0, 0, 0, BLD_OP_BSF, 12);
    // the poke must be ignored while the scan is still running
    run(OPC_ESC, 8'hBD, 8'hC0, 1, 0, 0, 0, 1, BLD_OP_BSR, 4);
    run(OPC_ESC, 8'hBD, 8'h06, 1, 0, 0, 0, 0, BLD_OP_BSR, 11);
    run(OPC_ESC, 8'hBD, 8'h06, 0, 5, 0, 0, 0, BLD_OP_BSR, 16);
    chk(fc, 9'h040, "bsr flags");
    for (int i = 0; i < 8; i++) begin
      run(OPC_ESC, 8'(8'hC8 + i), 8'h00, 0, 0, 0, 0, 0, BLD_OP_BSWAP,
          6);
      chk(reg_sel, i[2:0], "swap reg");
      chk(fc, 9'h000, "swap flags");
    end
  endtask

  task automatic t_bits;
    logic [7:0] ob [12] = '{8'hBA, 8'hBA, 8'hBA, 8'hBA, 8'hA3, 8'hA3,
      8'hBB, 8'hBB, 8'hB3, 8'hB3, 8'hAB, 8'hAB};
    logic [7:0] mr [12] = '{8'hE0, 8'hF8, 8'hF0, 8'hE8, 8'hC0, 8'h06,
      8'hC0, 8'h06, 8'hC0, 8'h06, 8'hC0, 8'h06};
    bld_op_type eo [12] = '{BLD_OP_BT, BLD_OP_BTC, BLD_OP_BTR, BLD_OP_BTS,
      BLD_OP_BT, BLD_OP_BT, BLD_OP_BTC, BLD_OP_BTC, BLD_OP_BTR, BLD_OP_BTR,
      BLD_OP_BTS, BLD_OP_BTS};
    int lat [12] = '{1, 2, 2, 2, 1, 7, 2, 8, 2, 8, 2, 8};
    for (int i = 0; i < 12; i++) begin
      run(OPC_ESC, ob[i], mr[i], 1, 0, 0, 0, 0, eo[i],
          lat[i]);
      chk({fc.cf_from_bit, fc.cf_w, fc.zf_w}, 3'h6, "bit flags");
      chk(mem_opnd, mr[i] == 8'h06, "bit mem");
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_add();
    t_and();
    t_arpl_blit_bound();
    t_scan_swap();
    t_bits();
    test_done();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end
endmodule
